/* File: common/adcc_cfg.svh */
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH

// Register offsets
`define ADCC_REG_PINFUNC 8'h08
`define ADCC_REG_CLKCFG 8'h09
`define ADCC_REG_STATUS 8'h0a
`define ADCC_REG_CLKDIV 8'h0b
`define ADCC_REG_OUTMODE 8'h14
`define ADCC_REG_SPAN 8'h18

// Reset values
`define ADCC_RST_PINFUNC 8'h00
`define ADCC_RST_CLKCFG 8'h01
`define ADCC_RST_CLKDIV 8'h00
`define ADCC_RST_OUTMODE 8'h30
`define ADCC_RST_SPAN 8'he0

// Field positions
`define ADCC_PINF_MSB 6
`define ADCC_PINF_LSB 5
`define ADCC_PWRCMD_MSB 1
`define ADCC_PWRCMD_LSB 0
`define ADCC_DCS_EN_BIT 0
`define ADCC_DIV_MSB 2
`define ADCC_DIV_LSB 0
`define ADCC_FMT_MSB 1
`define ADCC_FMT_LSB 0
`define ADCC_OEB_DATA_BIT 4
`define ADCC_OEB_DCO_BIT 5

// Span codes
`define ADCC_SPAN_1V00 8'hc0
`define ADCC_SPAN_1V14 8'hc8
`define ADCC_SPAN_1V33 8'hd0
`define ADCC_SPAN_1V60 8'hd8
`define ADCC_SPAN_2V00 8'he0

// Output codes
`define ADCC_MID_SCALE 10'h200

// Timing
`define ADCC_CLK_PERIOD_NS 50
`define ADCC_CLK_FREQ_KHZ 20000
`define ADCC_DCS_MIN_KHZ 20000
`define ADCC_RELOCK_MIN_NS 1500
`define ADCC_RELOCK_CYC \
  ((`ADCC_RELOCK_MIN_NS + `ADCC_CLK_PERIOD_NS - 1) / `ADCC_CLK_PERIOD_NS)
`define ADCC_PD_TIME_MAX 12'hfff
`define ADCC_STBY_WAKE_SHIFT 2

`endif

/* File: common/adcc_pkg.sv */
package adcc_pkg;
  // Output coding
  typedef enum logic [1:0] {
    FMT_OFFSET = 2'b00,
    FMT_TWOS = 2'b01,
    FMT_GRAY = 2'b10
  } adcc_fmt_type;
  // Function of the multi-function control pin
  typedef enum logic [1:0] {
    PINF_POWER_DOWN_PIN = 2'b00,
    PINF_OUT_DIS = 2'b01,
    PINF_STBY = 2'b10,
    PINF_NONE = 2'b11
  } adcc_pinf_type;
  // Power command field and power state
  typedef enum logic [1:0] {
    PWR_RUN = 2'b00,
    PWR_DOWN = 2'b01,
    PWR_STBY = 2'b10,
    PWR_WAKE = 2'b11
  } adcc_pwr_type;
endpackage : adcc_pkg

/* File: src/adcc_sync2.sv */
module adcc_sync2 #(
  parameter int W = 1
) (
  // Clock and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Asynchronous levels in, synchronised out
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_r;

  // Two stages; the first one feeds only the second
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else if (ce_i) begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule : adcc_sync2

/* File: src/adcc_clk_div.sv */
module adcc_clk_div (
  // Clock and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic run_i,
  // Configuration
  input wire logic [2:0] ratio_m1_i,
  input wire logic dcs_en_i,
  // Internal sample clock
  output logic stb_o,
  output logic clk_int_o
);
  logic [2:0] cnt_r;
  logic [2:0] ratio_prev_r;
  logic [3:0] twice_cnt;
  logic [3:0] div_n;

  // Strobe on count zero, aligned to an input rising edge
  assign stb_o = run_i && (cnt_r == 3'h0);
  assign twice_cnt = {cnt_r, 1'b0};
  assign div_n = {1'b0, ratio_m1_i} + 4'h1;
  // Rise always at the strobe; stabiliser only moves the fall
  assign clk_int_o = run_i && (dcs_en_i ? (twice_cnt < div_n)
                                        : (cnt_r == 3'h0));

  // Count 0 .. N-1, restart when the ratio changes
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 3'h0;
      ratio_prev_r <= 3'h0;
    end else if (ce_i) begin
      ratio_prev_r <= ratio_m1_i;
      if (!run_i || ratio_prev_r != ratio_m1_i || cnt_r >= ratio_m1_i)
        cnt_r <= 3'h0;
      else
        cnt_r <= cnt_r + 3'h1;
    end
  end

  sequence s_div4_gap;
    (stb_o && ce_i && run_i && ratio_m1_i == 3'd3 && ratio_prev_r == 3'd3)
    ##1 (ce_i && run_i && ratio_m1_i == 3'd3 && !stb_o) [*3];
  endsequence
  property p_div4_period;
    @(posedge clk_i) disable iff (rst_i) s_div4_gap |=> stb_o;
  endproperty
  a_div4_period: assert property (p_div4_period)
    else $error("divider strobe spacing wrong");

  property p_rise_at_strobe;
    @(posedge clk_i) disable iff (rst_i)
      (stb_o && !$past(stb_o) && ratio_m1_i != 3'd0) |-> clk_int_o
      && !$past(clk_int_o);
  endproperty
  a_rise_at_strobe: assert property (p_rise_at_strobe)
    else $error("internal clock does not rise at strobe");

  property p_dcs_half;
    @(posedge clk_i) disable iff (rst_i)
      (stb_o && dcs_en_i && ratio_m1_i == 3'd3 && ratio_prev_r == 3'd3
       && ce_i) |=> clk_int_o ##1 !clk_int_o;
  endproperty
  a_dcs_half: assert property (p_dcs_half)
    else $error("stabilised clock not half high");
endmodule : adcc_clk_div

/* File: src/adcc_top.sv */
// Summary of operation
// - Span register codes c0,c8,d0,d8,e0 select 1.0 to 2.0 V spans.
// - Sense pin low selects internal reference; tied high selects external.
// - Input clock divider ratio is any integer from 1 to 8.
// - Stabiliser regenerates only the falling edge, nominal 50% high.
// - Stabiliser loop need not work below a 20 MHz clock.
// - Serial mode: power-down by register command or control pin.
// - Pin mode: power-down pin high powers down, low restores.
// - All output drivers go high impedance while powered down.
// - Power-down stops reference, buffer, bias, clock; wake grows with time.
// - Serial mode standby keeps reference on for faster wake-up.
// - Pin mode: format pin low offset binary, high twos complement.
// - Pin mode: disable strap low runs, high disables outputs.
// - Serial mode: offset binary, twos complement or Gray coding.
// - Bits 6:5 of register 08 choose the control pin function.
// - Data and data clock drivers three-state independently via pin.
// - Output-disable function: pin low enables, high three-states drivers.
// - Each sample is taken on the internal clock rising edge.
// - Zero input gives 200h offset, 000h twos; overrange passes through.
`include "adcc_cfg.svh"
module adcc_top
  import adcc_pkg::*;
(
  // Clock, reset, freeze
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Register port from the serial engine
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Configuration pins
  input wire logic serial_mode_pin_i,
  input wire logic sense_pin_i,
  input wire logic power_down_pin_i,
  input wire logic format_select_pin_i,
  input wire logic output_disable_strap_pin_i,
  input wire logic mode_pin_i,
  // Converter core
  input wire logic [9:0] core_data_i,
  input wire logic core_ovr_i,
  // Output drivers
  output logic [9:0] data_o,
  output logic ovr_o,
  output logic data_oe_n_o,
  output logic data_clock_output_o,
  output logic dco_oe_n_o,
  // Analog controls
  output logic ref_int_en_o,
  output logic ref_buf_en_o,
  output logic bias_en_o,
  output logic clk_run_o,
  output logic [2:0] span_sel_o,
  output logic duty_cycle_stabilizer_o,
  output logic dcs_locked_o
);
  logic [7:0] pinfunc_r;
  logic [7:0] clkcfg_r;
  logic [7:0] clkdiv_r;
  logic [7:0] outmode_r;
  logic [7:0] span_r;
  logic [5:0] pins_s;
  logic serial_s, ext_ref_s, power_down_pin_s, fmt_pin_s, strap_s, mode_s;
  adcc_pwr_type pwr_state_r, pwr_state_nxt;
  adcc_pwr_type pwr_cmd;
  adcc_pinf_type pinf;
  adcc_fmt_type fmt_sel;
  logic [11:0] pd_time_r;
  logic [11:0] wake_cnt_r;
  logic [5:0] lock_cnt_r;
  logic [2:0] ratio_prev_r;
  logic dcs_act_prev_r;
  logic pd_req, sb_req, pwr_off, dis_data, dis_dco;
  logic div_stb, div_clk;
  logic [2:0] ratio_m1;
  logic [31:0] div_n_w;
  logic dcs_rate_ok, dcs_act;
  logic [9:0] fmt_data;
  logic [2:0] span_dec;
  logic [7:0] rd_mux;
  logic wr_pinf, wr_clkcfg, wr_clkdiv, wr_outmode, wr_span;

  // Pin synchronisers
  adcc_sync2 #(.W(6)) u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .async_i({serial_mode_pin_i, sense_pin_i, power_down_pin_i,
              format_select_pin_i, output_disable_strap_pin_i, mode_pin_i}),
    .sync_o(pins_s)
  );
  assign {serial_s, ext_ref_s, power_down_pin_s, fmt_pin_s, strap_s, mode_s} = pins_s;

  // Register write decode
  assign wr_pinf = reg_wr_i && (reg_addr_i == `ADCC_REG_PINFUNC);
  assign wr_clkcfg = reg_wr_i && (reg_addr_i == `ADCC_REG_CLKCFG);
  assign wr_clkdiv = reg_wr_i && (reg_addr_i == `ADCC_REG_CLKDIV);
  assign wr_outmode = reg_wr_i && (reg_addr_i == `ADCC_REG_OUTMODE);
  assign wr_span = reg_wr_i && (reg_addr_i == `ADCC_REG_SPAN);

  // Configuration registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pinfunc_r <= `ADCC_RST_PINFUNC;
      clkcfg_r <= `ADCC_RST_CLKCFG;
      clkdiv_r <= `ADCC_RST_CLKDIV;
      outmode_r <= `ADCC_RST_OUTMODE;
      span_r <= `ADCC_RST_SPAN;
    end else if (ce_i) begin
      if (wr_pinf) pinfunc_r <= reg_wdata_i;
      if (wr_clkcfg) clkcfg_r <= reg_wdata_i;
      if (wr_clkdiv) clkdiv_r <= reg_wdata_i;
      if (wr_outmode) outmode_r <= reg_wdata_i;
      if (wr_span) span_r <= reg_wdata_i;
    end
  end

  // Field decode
  assign pinf =
    adcc_pinf_type'(pinfunc_r[`ADCC_PINF_MSB:`ADCC_PINF_LSB]);
  assign pwr_cmd =
    adcc_pwr_type'(pinfunc_r[`ADCC_PWRCMD_MSB:`ADCC_PWRCMD_LSB]);
  assign ratio_m1 = clkdiv_r[`ADCC_DIV_MSB:`ADCC_DIV_LSB];

  // Span code decode; unlisted codes fall back to full span
  assign span_dec = (span_r == `ADCC_SPAN_1V00) ? 3'd0 :
                    (span_r == `ADCC_SPAN_1V14) ? 3'd1 :
                    (span_r == `ADCC_SPAN_1V33) ? 3'd2 :
                    (span_r == `ADCC_SPAN_1V60) ? 3'd3 : 3'd4;

  // Stabiliser only runs when the divided rate reaches its floor
  assign div_n_w = 32'(ratio_m1) + 32'd1;
  assign dcs_rate_ok = 32'(`ADCC_CLK_FREQ_KHZ) >=
                       32'(`ADCC_DCS_MIN_KHZ) * div_n_w;
  assign dcs_act = clkcfg_r[`ADCC_DCS_EN_BIT] && dcs_rate_ok;

  // Power requests: pin mode uses the power-down pin only
  assign pd_req = serial_s
    ? (pwr_cmd == PWR_DOWN || (pinf == PINF_POWER_DOWN_PIN && mode_s))
    : power_down_pin_s;
  assign sb_req = serial_s &&
    (pwr_cmd == PWR_STBY || (pinf == PINF_STBY && mode_s));

  // Power state sequencing
  always_comb begin
    pwr_state_nxt = pwr_state_r;
    case (pwr_state_r)
      PWR_RUN: begin
        if (pd_req) pwr_state_nxt = PWR_DOWN;
        else if (sb_req) pwr_state_nxt = PWR_STBY;
      end
      PWR_DOWN, PWR_STBY: begin
        if (pd_req) pwr_state_nxt = PWR_DOWN;
        else if (sb_req) pwr_state_nxt = PWR_STBY;
        else pwr_state_nxt = PWR_WAKE;
      end
      PWR_WAKE: begin
        if (pd_req) pwr_state_nxt = PWR_DOWN;
        else if (sb_req) pwr_state_nxt = PWR_STBY;
        else if (wake_cnt_r == 12'h000) pwr_state_nxt = PWR_RUN;
      end
      default: pwr_state_nxt = PWR_RUN;
    endcase
  end

  // State, time spent down, and a wake delay that follows it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pwr_state_r <= PWR_RUN;
      pd_time_r <= 12'h000;
      wake_cnt_r <= 12'h000;
    end else if (ce_i) begin
      pwr_state_r <= pwr_state_nxt;
      if (pwr_state_r == PWR_DOWN || pwr_state_r == PWR_STBY) begin
        if (pd_time_r != `ADCC_PD_TIME_MAX) pd_time_r <= pd_time_r + 12'h1;
      end else if (pwr_state_r == PWR_RUN) begin
        pd_time_r <= 12'h000;
      end
      if (pwr_state_nxt == PWR_WAKE && pwr_state_r != PWR_WAKE)
        wake_cnt_r <= (pwr_state_r == PWR_STBY)
          ? (pd_time_r >> `ADCC_STBY_WAKE_SHIFT) : pd_time_r;
      else if (pwr_state_r == PWR_WAKE && wake_cnt_r != 12'h000)
        wake_cnt_r <= wake_cnt_r - 12'h1;
    end
  end

  // Driver disables
  assign pwr_off = (pwr_state_r != PWR_RUN);
  assign dis_data = serial_s
    ? (pinf == PINF_OUT_DIS && mode_s && outmode_r[`ADCC_OEB_DATA_BIT])
    : strap_s;
  assign dis_dco = serial_s
    ? (pinf == PINF_OUT_DIS && mode_s && outmode_r[`ADCC_OEB_DCO_BIT])
    : strap_s;

  // Output coding
  assign fmt_sel = serial_s
    ? adcc_fmt_type'(outmode_r[`ADCC_FMT_MSB:`ADCC_FMT_LSB])
    : (fmt_pin_s ? FMT_TWOS : FMT_OFFSET);
  assign fmt_data = (fmt_sel == FMT_TWOS) ? {~core_data_i[9], core_data_i[8:0]}
                  : (fmt_sel == FMT_GRAY) ? (core_data_i ^ (core_data_i >> 1))
                  : core_data_i;

  // Divider and stabiliser
  adcc_clk_div u_clk_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .run_i(clk_run_o),
    .ratio_m1_i(ratio_m1),
    .dcs_en_i(dcs_act),
    .stb_o(div_stb),
    .clk_int_o(div_clk)
  );

  // Relock window after a clock change, reported as status
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ratio_prev_r <= 3'h0;
      dcs_act_prev_r <= 1'b0;
      lock_cnt_r <= 6'h00;
    end else if (ce_i) begin
      ratio_prev_r <= ratio_m1;
      dcs_act_prev_r <= dcs_act;
      if (ratio_prev_r != ratio_m1 || dcs_act_prev_r != dcs_act || !clk_run_o)
        lock_cnt_r <= 6'(`ADCC_RELOCK_CYC);
      else if (lock_cnt_r != 6'h00)
        lock_cnt_r <= lock_cnt_r - 6'h1;
    end
  end

  // Sampled data and driver controls
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_o <= 10'h000;
      ovr_o <= 1'b0;
      data_oe_n_o <= 1'b1;
      dco_oe_n_o <= 1'b1;
      data_clock_output_o <= 1'b0;
    end else if (ce_i) begin
      if (div_stb && pwr_state_r == PWR_RUN) begin
        data_o <= fmt_data;
        ovr_o <= core_ovr_i;
      end
      data_oe_n_o <= pwr_off || dis_data;
      dco_oe_n_o <= pwr_off || dis_dco;
      data_clock_output_o <= div_clk;
    end
  end

  // Analog enables and status outputs
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_int_en_o <= 1'b0;
      ref_buf_en_o <= 1'b0;
      bias_en_o <= 1'b0;
      clk_run_o <= 1'b0;
      span_sel_o <= 3'd4;
      duty_cycle_stabilizer_o <= 1'b0;
      dcs_locked_o <= 1'b0;
    end else if (ce_i) begin
      ref_int_en_o <= !ext_ref_s && pwr_state_r != PWR_DOWN;
      ref_buf_en_o <= !pwr_off || pwr_state_r == PWR_WAKE;
      bias_en_o <= !pwr_off || pwr_state_r == PWR_WAKE;
      clk_run_o <= !pwr_off || pwr_state_r == PWR_WAKE;
      span_sel_o <= span_dec;
      duty_cycle_stabilizer_o <= dcs_act;
      dcs_locked_o <= dcs_act && lock_cnt_r == 6'h00;
    end
  end

  // Register read mux; unmapped offsets read zero
  assign rd_mux =
    (reg_addr_i == `ADCC_REG_PINFUNC) ? pinfunc_r :
    (reg_addr_i == `ADCC_REG_CLKCFG) ? clkcfg_r :
    (reg_addr_i == `ADCC_REG_CLKDIV) ? clkdiv_r :
    (reg_addr_i == `ADCC_REG_OUTMODE) ? outmode_r :
    (reg_addr_i == `ADCC_REG_SPAN) ? span_r :
    (reg_addr_i == `ADCC_REG_STATUS) ?
      {3'h0, ext_ref_s, pwr_state_r, pwr_state_r == PWR_RUN, dcs_locked_o} :
    8'h00;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) reg_rdata_o <= 8'h00;
    else if (ce_i && reg_rd_i) reg_rdata_o <= rd_mux;
  end

  property p_span_decode;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && span_r == `ADCC_SPAN_1V33) |=> span_sel_o == 3'd2;
  endproperty
  a_span_decode: assert property (p_span_decode)
    else $error("span code not decoded");

  property p_ext_ref;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && ext_ref_s) |=> !ref_int_en_o;
  endproperty
  a_ext_ref: assert property (p_ext_ref)
    else $error("internal reference on with external selected");

  property p_pin_power_down_pin;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && !serial_s && power_down_pin_s && pwr_state_r == PWR_RUN)
      |=> pwr_state_r == PWR_DOWN;
  endproperty
  a_pin_power_down_pin: assert property (p_pin_power_down_pin)
    else $error("power-down pin ignored");

  property p_reg_power_down_pin;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && serial_s && pwr_cmd == PWR_DOWN) |=> pwr_state_r == PWR_DOWN;
  endproperty
  a_reg_power_down_pin: assert property (p_reg_power_down_pin)
    else $error("power-down command ignored");

  sequence s_held_down;
    (ce_i && pwr_state_r == PWR_DOWN) [*2];
  endsequence
  property p_down_hiz;
    @(posedge clk_i) disable iff (rst_i)
      s_held_down |-> data_oe_n_o && dco_oe_n_o && !clk_run_o && !bias_en_o;
  endproperty
  a_down_hiz: assert property (p_down_hiz)
    else $error("drivers or clock active in power-down");

  property p_stby_ref;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && pwr_state_r == PWR_STBY && !ext_ref_s)
      |=> ref_int_en_o && !ref_buf_en_o;
  endproperty
  a_stby_ref: assert property (p_stby_ref)
    else $error("standby reference state wrong");

  property p_oeb_pin;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && serial_s && pinf == PINF_OUT_DIS && mode_s
       && outmode_r[`ADCC_OEB_DATA_BIT]) |=> data_oe_n_o;
  endproperty
  a_oeb_pin: assert property (p_oeb_pin)
    else $error("data drivers not disabled by control pin");

  property p_twos_zero;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && div_stb && pwr_state_r == PWR_RUN && fmt_sel == FMT_TWOS
       && core_data_i == `ADCC_MID_SCALE) |=> data_o == 10'h000;
  endproperty
  a_twos_zero: assert property (p_twos_zero)
    else $error("twos complement zero code wrong");
endmodule : adcc_top

/* File: verif/adcc_host_model.sv */
`include "adcc_cfg.svh"
module adcc_host_model
  import adcc_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Register port towards the device
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [7:0] reg_rdata_i,
  // Strap and control pin levels
  output logic serial_mode_o,
  output logic sense_o,
  output logic power_down_o,
  output logic format_o,
  output logic strap_o,
  output logic mode_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle at time zero: serial mode, all other pins low
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    {serial_mode_o, sense_o, power_down_o, format_o, strap_o, mode_o} = 6'h20;
  end

  // One byte write; released lines carry inverted values, not stale ones
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask : wr

  // One byte read; data is taken once the answering edge has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    @(negedge clk_i);
    d = reg_rdata_i;
  endtask : rd

  // Pin order: serial, sense, power-down, format, strap, mode
  task automatic pins(input logic [5:0] p);
    @(posedge clk_i);
    {serial_mode_o, sense_o, power_down_o, format_o, strap_o, mode_o} <= p;
  endtask : pins

  // Stabiliser enable bit set for every ratio (it runs at ratio 1 only), then its relock time is waited out
  task automatic set_ratio(input int n);
    wr(`ADCC_REG_CLKCFG, 8'h01);
    wr(`ADCC_REG_CLKDIV, 8'(n - 1));
    repeat (`ADCC_RELOCK_CYC + 2) @(posedge clk_i);
  endtask : set_ratio
endmodule : adcc_host_model

/* File: verif/adcc_top_tb_top.sv */
`include "adcc_cfg.svh"
module adcc_top_tb_top
  import adcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // Stimulus, host wires and design outputs
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic [9:0] core_data_i = `ADCC_MID_SCALE;
  logic core_ovr_i = 1'b0;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rd_v;
  logic reg_wr_i, reg_rd_i, serial_mode_pin_i, sense_pin_i, mode_pin_i;
  logic power_down_pin_i, format_select_pin_i, output_disable_strap_pin_i;
  logic [9:0] data_o;
  logic [2:0] span_sel_o;
  logic ovr_o, data_oe_n_o, data_clock_output_o, dco_oe_n_o, ref_int_en_o;
  logic ref_buf_en_o, bias_en_o, clk_run_o;
  logic duty_cycle_stabilizer_o, dcs_locked_o;
  int failures = 0;
  int tests_run = 0;
  int w1, w2, hi;
  logic [7:0] spans [5] = '{8'hc0, 8'hc8, 8'hd0, 8'hd8, 8'he0};
  logic [9:0] fmt_exp [3] = '{10'h200, 10'h000, 10'h300};
  logic [9:0] fmt_alt [3] = '{10'h0ff, 10'h2ff, 10'h080};

  // 20 MHz clock
  always #25 clk_i = ~clk_i;

  adcc_host_model host (
    .clk_i(clk_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
    .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o),
    .serial_mode_o(serial_mode_pin_i), .sense_o(sense_pin_i),
    .power_down_o(power_down_pin_i), .format_o(format_select_pin_i),
    .strap_o(output_disable_strap_pin_i), .mode_o(mode_pin_i)
  );

  adcc_top uut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .serial_mode_pin_i(serial_mode_pin_i), .sense_pin_i(sense_pin_i),
    .power_down_pin_i(power_down_pin_i),
    .format_select_pin_i(format_select_pin_i),
    .output_disable_strap_pin_i(output_disable_strap_pin_i),
    .mode_pin_i(mode_pin_i), .core_data_i(core_data_i),
    .core_ovr_i(core_ovr_i), .data_o(data_o), .ovr_o(ovr_o),
    .data_oe_n_o(data_oe_n_o), .data_clock_output_o(data_clock_output_o),
    .dco_oe_n_o(dco_oe_n_o), .ref_int_en_o(ref_int_en_o),
    .ref_buf_en_o(ref_buf_en_o), .bias_en_o(bias_en_o),
    .clk_run_o(clk_run_o), .span_sel_o(span_sel_o),
    .duty_cycle_stabilizer_o(duty_cycle_stabilizer_o),
    .dcs_locked_o(dcs_locked_o)
  );

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Let n edges pass, then sample mid-cycle
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask : settle

  // Bounded wait for the data drivers to come back
  task automatic wait_wake(output int n);
    n = 0;
    while (data_oe_n_o !== 1'b0 && n < 5000) begin
      @(negedge clk_i);
      n++;
    end
  endtask : wait_wake

  // Pin-mode power-down for a dwell, then release and time the wake-up
  task automatic down_up(input int dwell, output int wake);
    host.pins(6'b001000);
    repeat (dwell) @(negedge clk_i);
    check({data_oe_n_o, dco_oe_n_o}, 16'h3);
    check({ref_int_en_o, ref_buf_en_o, bias_en_o, clk_run_o}, 16'h0);
    host.pins(6'b000000);
    wait_wake(wake);
    check({data_oe_n_o, clk_run_o}, 16'h1);
  endtask : down_up

  // Verdict and end of run
  task automatic test_done();
    if (failures == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  // Watchdog against a hang
  initial begin
    repeat (40000) @(posedge clk_i);
    failures++;
    test_done();
  end

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    settle(4);
    // Reset state and an unmapped place
    host.rd(`ADCC_REG_SPAN, rd_v);
    check(rd_v, 16'h00e0);
    host.rd(`ADCC_REG_PINFUNC, rd_v);
    check(rd_v, 16'h0000);
    host.rd(8'h33, rd_v);
    check(rd_v, 16'h0000);
    check({span_sel_o, ref_int_en_o, data_oe_n_o}, 16'h12);
    // Every span code, read back too
    for (int i = 0; i < 5; i++) begin
      host.wr(`ADCC_REG_SPAN, spans[i]);
      settle(1);
      check(span_sel_o, 16'(i));
      host.rd(`ADCC_REG_SPAN, rd_v);
      check(rd_v, spans[i]);
    end
    // A write while the clock enable is low is not taken
    @(posedge clk_i);
    ce_i <= 1'b0;
    host.wr(`ADCC_REG_SPAN, `ADCC_SPAN_1V00);
    @(posedge clk_i);
    ce_i <= 1'b1;
    host.rd(`ADCC_REG_SPAN, rd_v);
    check(rd_v, 16'h00e0);
    // Reference sense pin
    host.pins(6'b110000);
    settle(5);
    check(ref_int_en_o, 16'h0);
    host.pins(6'b100000);
    settle(5);
    check(ref_int_en_o, 16'h1);
    // Pin-mode straps are ignored in serial mode
    host.pins(6'b101110);
    settle(5);
    check({data_oe_n_o, data_o}, 16'h0200);
    // Pin mode: format pin and overrange
    host.pins(6'b000000);
    settle(5);
    check(data_o, 16'h0200);
    host.pins(6'b000100);
    core_ovr_i <= 1'b1;
    settle(5);
    check({ovr_o, data_o}, 16'h0400);
    @(posedge clk_i);
    core_ovr_i <= 1'b0;
    // Pin mode: output disable strap
    host.pins(6'b000010);
    settle(5);
    check({data_oe_n_o, dco_oe_n_o, clk_run_o}, 16'h7);
    host.pins(6'b000000);
    settle(5);
    check({data_oe_n_o, dco_oe_n_o}, 16'h0);
    // Wake-up time grows with time spent down
    down_up(20, w1);
    down_up(420, w2);
    check(16'(w2 > w1 + 300), 16'h1);
    // Serial mode: register power-down, standby, then mode pin power-down
    host.pins(6'b100000);
    settle(5);
    host.wr(`ADCC_REG_PINFUNC, 8'h01);
    settle(3);
    check({data_oe_n_o, dco_oe_n_o, ref_int_en_o, clk_run_o}, 16'hc);
    host.wr(`ADCC_REG_PINFUNC, 8'h02);
    settle(3);
    check({data_oe_n_o, ref_int_en_o}, 16'h3);
    host.wr(`ADCC_REG_PINFUNC, 8'h00);
    wait_wake(hi);
    check(data_oe_n_o, 16'h0);
    host.pins(6'b100001);
    settle(5);
    check({data_oe_n_o, clk_run_o}, 16'h2);
    host.pins(6'b100000);
    wait_wake(hi);
    check(data_oe_n_o, 16'h0);
    // Output-disable function, both drivers and each alone
    host.wr(`ADCC_REG_PINFUNC, 8'h20);
    host.pins(6'b100001);
    settle(5);
    check({data_oe_n_o, dco_oe_n_o, clk_run_o}, 16'h7);
    host.wr(`ADCC_REG_OUTMODE, 8'h10);
    settle(2);
    check({data_oe_n_o, dco_oe_n_o}, 16'h2);
    host.wr(`ADCC_REG_OUTMODE, 8'h20);
    settle(2);
    check({data_oe_n_o, dco_oe_n_o}, 16'h1);
    host.pins(6'b100000);
    settle(5);
    check({data_oe_n_o, dco_oe_n_o}, 16'h0);
    // Standby through the control pin keeps the reference on
    host.wr(`ADCC_REG_PINFUNC, 8'h40);
    host.pins(6'b100001);
    settle(5);
    check({data_oe_n_o, ref_int_en_o, ref_buf_en_o}, 16'h6);
    host.pins(6'b100000);
    wait_wake(hi);
    check(data_oe_n_o, 16'h0);
    // All three output codings of a zero and an off-centre input
    for (int f = 0; f < 3; f++) begin
      host.wr(`ADCC_REG_OUTMODE, 8'h30 | 8'(f));
      settle(2);
      check(data_o, fmt_exp[f]);
      @(posedge clk_i);
      core_data_i <= 10'h0ff;
      settle(2);
      check(data_o, fmt_alt[f]);
      @(posedge clk_i);
      core_data_i <= `ADCC_MID_SCALE;
    end
    // Divider ratios 1 to 8: eight high cycles per eight periods
    for (int n = 1; n <= 8; n++) begin
      host.set_ratio(n);
      settle(1);
      check({duty_cycle_stabilizer_o, dcs_locked_o},
            (n == 1) ? 16'h3 : 16'h0);
      hi = 0;
      for (int c = 0; c < 8 * n; c++) begin
        @(negedge clk_i);
        hi += int'(data_clock_output_o === 1'b1);
      end
      check(16'(hi), 16'h8);
    end
    host.set_ratio(1);
    // Status: internal reference, running, stabiliser relocked
    host.rd(`ADCC_REG_STATUS, rd_v);
    check(rd_v, 16'h0003);
    // Reset in mid-run brings the pin function back to power-down
    @(posedge clk_i);
    rst_i <= 1'b1;
    settle(2);
    @(posedge clk_i);
    rst_i <= 1'b0;
    host.rd(`ADCC_REG_PINFUNC, rd_v);
    check(rd_v, 16'h0000);
    test_done();
  end
endmodule : adcc_top_tb_top
